/* File: common/dic_pkg.sv */
package dic_pkg;
   // ------------------------------------------------------------
   // clock and watchdog timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned WDOG_WINDOW_S = 4;
   localparam int unsigned WDOG_CYCLES   = WDOG_WINDOW_S * CLK_HZ;
   localparam int unsigned WDOG_CNT_W    = 28;

   // ------------------------------------------------------------
   // register indices, byte address is four times the index
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W       = 8;
   localparam logic [3:0]  REG_CTL2_IDX = 4'h2;
   localparam logic [3:0]  REG_MASK_IDX = 4'h3;
   localparam logic [3:0]  REG_SRC_IDX  = 4'h4;
   localparam logic [3:0]  REG_HOOK_IDX = 4'h5;

   // control_two fields
   localparam int unsigned CTL2_PIN_SEL   = 7;
   localparam int unsigned CTL2_POLARITY  = 6;
   localparam int unsigned CTL2_WDOG_ON   = 4;
   localparam int unsigned CTL2_RING_BOTH = 2;
   localparam int unsigned CTL2_HYBRID    = 1;
   localparam int unsigned CTL2_RX_ON     = 0;
   localparam logic [7:0]  CTL2_RW_BITS   = 8'hD7;
   localparam logic [7:0]  CTL2_RST       = 8'h00;
   localparam logic [7:0]  MASK_RST       = 8'h00;
   localparam logic [7:0]  SRC_RST        = 8'h00;

   // hook register field
   localparam int unsigned HOOK_OFFHOOK = 0;
   localparam logic        HOOK_RST     = 1'b0;

   // source flag positions, shared by mask and source registers
   localparam int unsigned EV_RING     = 7;
   localparam int unsigned EV_RX_OVL   = 6;
   localparam int unsigned EV_FRAME    = 5;
   localparam int unsigned EV_BILLING  = 4;
   localparam int unsigned EV_DROPOUT  = 3;
   localparam int unsigned EV_LOOP_MAX = 2;
   localparam int unsigned EV_TIP_GND  = 1;
   localparam int unsigned EV_POL_FLIP = 0;

   // bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   localparam int unsigned LCS_W = 5;

   typedef struct packed {
      logic             ring_active;
      logic             rx_overload;
      logic             frame_lost;
      logic             billing_tone;
      logic             dropout;
      logic [LCS_W-1:0] loop_current_field;
      logic             tip_ground_status;
      logic             line_voltage_msb;
   } dic_line_ev_t;

   typedef struct packed {
      logic              hsel;
      logic [ADDR_W-1:0] haddr;
      logic [1:0]        htrans;
      logic              hwrite;
      logic [2:0]        hsize;
      logic [31:0]       hwdata;
      logic              hready;
   } dic_ahb_req_t;
endpackage

/* File: rtl/dic_event_detect.sv */
`timescale 1ns/1ps
module dic_event_detect
   import dic_pkg::*;
#(
   parameter bit POL_SUPPORT = 1'b1
)(
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire dic_line_ev_t line_ev,
   input  wire logic         ring_both,
   output logic [7:0]        set_pulse
);
   // ------------------------------------------------------------
   // previous samples of each line condition
   // ------------------------------------------------------------
   dic_line_ev_t prev_q;
   logic         lcs_max_now;
   logic         lcs_max_prev;
   logic         primed_q;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         prev_q <= '0;
      else
         prev_q <= line_ev;
   end

   assign lcs_max_now  = &line_ev.loop_current_field;
   assign lcs_max_prev = &prev_q.loop_current_field;

   // first edge after reset only primes the history, so a line
   // voltage bit already high is not taken for a reversal
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         primed_q <= 1'b0;
      else
         primed_q <= 1'b1;
   end

   // one pulse per new condition, level inputs would otherwise refire
   always_comb
   begin
      set_pulse = '0;
      set_pulse[EV_RING] = (line_ev.ring_active && !prev_q.ring_active)
                         || (ring_both && !line_ev.ring_active && prev_q.ring_active);
      set_pulse[EV_RX_OVL]   = line_ev.rx_overload && !prev_q.rx_overload;
      set_pulse[EV_FRAME]    = line_ev.frame_lost && !prev_q.frame_lost;
      set_pulse[EV_BILLING]  = line_ev.billing_tone && !prev_q.billing_tone;
      set_pulse[EV_DROPOUT]  = line_ev.dropout && !prev_q.dropout;
      set_pulse[EV_LOOP_MAX] = lcs_max_now && !lcs_max_prev;
      set_pulse[EV_TIP_GND]  = line_ev.tip_ground_status && !prev_q.tip_ground_status;
      // either direction of the polarity bit is a reversal
      set_pulse[EV_POL_FLIP] = POL_SUPPORT && primed_q
                             && (line_ev.line_voltage_msb != prev_q.line_voltage_msb);
   end
endmodule // dic_event_detect

/* File: rtl/dic_watchdog.sv */
`timescale 1ns/1ps
module dic_watchdog
   import dic_pkg::*;
#(
   parameter int unsigned CYCLES = WDOG_CYCLES,
   parameter int unsigned CNT_W  = WDOG_CNT_W
)(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic enable,
   input  wire logic access,
   output logic      timeout
);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

   logic [CNT_W-1:0] count_q;

   // ------------------------------------------------------------
   // window counter, restarted by every register access
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         count_q <= '0;
      else if (!enable || access || count_q == LAST)
         count_q <= '0;
      else
         count_q <= count_q + 1'b1;
   end

   // pulse when the whole window passed with no access
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         timeout <= 1'b0;
      else
         timeout <= enable && !access && count_q == LAST;
   end

   wdog_restart_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      access |=> count_q == '0 && !timeout)
      else $error("watchdog not restarted by access");
endmodule // dic_watchdog

/* File: rtl/dic_irq_ctl.sv */
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
// How it works
// - select bit picks interrupt or monitor output
// - polarity bit 0 low, 1 high active
// - watchdog enable cleared only by reset
// - no access for 4 s forces on-hook
// - any register access restarts watchdog count
// - timeout clears off-hook bit, rewrite restores
// - ring flag at burst start, optionally end
// - hybrid bit connects echo hybrid when 1
// - receive bit enables receive path when 1
// - ring mask gates ring interrupt
// - overload mask gates receive overload interrupt
// - frame mask gates frame-lock loss interrupt
// - billing mask gates billing tone interrupt
// - dropout mask gates supply dropout interrupt
// - loop mask gates all-ones loop current
// - tip mask gates tip-ground interrupt
// - polarity flag from line voltage bit changes
// - flags stay set until written zero
// - pin interrupts need flag, mask, select
module dic_irq_ctl
   import dic_pkg::*;
#(
   parameter int unsigned WDOG_LEN    = WDOG_CYCLES,
   parameter bit          POL_SUPPORT = 1'b1
)(
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire dic_ahb_req_t ahb_req,
   output logic              hreadyout,
   output logic              hresp,
   output logic [31:0]       hrdata,
   input  wire dic_line_ev_t line_ev,
   input  wire logic         monitor_stream,
   output logic              monitor_or_irq_pin,
   output logic              offhook_ctl,
   output logic              hybrid_connect,
   output logic              rx_path_on
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0] ctl2_q;
   logic [7:0] mask_q;
   logic [7:0] flags_q;
   logic       offhook_q;
   logic       wr_pend_q;
   logic [3:0] wr_idx_q;
   logic       rd_late_q;
   logic [3:0] rd_idx_q;
   logic [7:0] set_pulse;
   logic       wd_timeout;
   logic       addr_ok;
   logic       access;
   logic       rd_now;
   logic       any_irq;
   logic [3:0] req_idx;
   logic [7:0] wbyte;

   // decode the register index from a byte address, zero when misaligned or above 0x3F
   function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
      logic [3:0] idx;
      idx = a[5:2];
      if (a[ADDR_W-1:6] != '0 || a[1:0] != 2'h0)
         return 4'h0;
      return idx;
   endfunction

   function automatic logic mapped(input logic [3:0] idx);
      return idx == REG_CTL2_IDX || idx == REG_MASK_IDX
          || idx == REG_SRC_IDX || idx == REG_HOOK_IDX;
   endfunction

   // readback, reserved bits of control_two read as zero
   function automatic logic [7:0] read_mux(input logic [3:0] idx, input logic [7:0] c,
                                           input logic [7:0] m, input logic [7:0] f,
                                           input logic h);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         REG_CTL2_IDX: v = c & CTL2_RW_BITS;
         REG_MASK_IDX: v = m;
         REG_SRC_IDX:  v = f;
         REG_HOOK_IDX: v = {7'h00, h};
         default:      v = 8'h00;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // bus address phase
   // ------------------------------------------------------------
   assign req_idx = reg_index(ahb_req.haddr);
   assign addr_ok = ahb_req.hsel && ahb_req.hready && ahb_req.htrans == HTRANS_NONSEQ;
   assign access  = addr_ok && mapped(req_idx);
   assign rd_now  = addr_ok && !ahb_req.hwrite;
   assign wbyte   = ahb_req.hwdata[7:0];

   // writes land in the data phase, so remember where they go
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 4'h0;
      end
      else
      begin
         wr_pend_q <= addr_ok && ahb_req.hwrite && mapped(req_idx);
         wr_idx_q  <= req_idx;
      end
   end

   // a read right behind a write waits one cycle so it sees the new value
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_late_q <= 1'b0;
         rd_idx_q  <= 4'h0;
         hreadyout <= 1'b1;
         hrdata    <= '0;
      end
      else if (rd_late_q)
      begin
         rd_late_q <= 1'b0;
         hreadyout <= 1'b1;
         hrdata    <= {24'h000000, read_mux(rd_idx_q, ctl2_q, mask_q, flags_q, offhook_q)};
      end
      else if (rd_now && wr_pend_q)
      begin
         rd_late_q <= 1'b1;
         rd_idx_q  <= req_idx;
         hreadyout <= 1'b0;
      end
      else if (rd_now)
         hrdata <= {24'h000000, read_mux(req_idx, ctl2_q, mask_q, flags_q, offhook_q)};
   end

   // only OKAY is ever answered, unmapped reads return zero
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         hresp <= HRESP_OKAY;
      else
         hresp <= HRESP_OKAY;
   end

   // ------------------------------------------------------------
   // control and mask registers
   // ------------------------------------------------------------
   // watchdog enable is set-only from software, so a runaway
   // driver cannot disable the safety net it depends on
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctl2_q <= CTL2_RST;
      else if (wr_pend_q && wr_idx_q == REG_CTL2_IDX)
      begin
         ctl2_q <= wbyte & CTL2_RW_BITS;
         ctl2_q[CTL2_WDOG_ON] <= wbyte[CTL2_WDOG_ON] || ctl2_q[CTL2_WDOG_ON];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         mask_q <= MASK_RST;
      else if (wr_pend_q && wr_idx_q == REG_MASK_IDX)
         mask_q <= wbyte;
   end

   // ------------------------------------------------------------
   // hook control and watchdog
   // ------------------------------------------------------------
   dic_watchdog #(
      .CYCLES (WDOG_LEN),
      .CNT_W  (WDOG_CNT_W)
   ) u_wdog (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .enable  (ctl2_q[CTL2_WDOG_ON]),
      .access  (access),
      .timeout (wd_timeout)
   );

   // timeout and a hook write never meet, the write's access restarts the window
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         offhook_q <= HOOK_RST;
      else if (wd_timeout)
         offhook_q <= 1'b0;
      else if (wr_pend_q && wr_idx_q == REG_HOOK_IDX)
         offhook_q <= wbyte[HOOK_OFFHOOK];
   end

   // ------------------------------------------------------------
   // watchdog reference for the checks
   // ------------------------------------------------------------
   // counts quiet cycles on its own, so the window check does not
   // lean on the very counter it is meant to judge
   localparam logic [WDOG_CNT_W-1:0] QUIET_LEN = WDOG_CNT_W'(WDOG_LEN);

   logic [WDOG_CNT_W-1:0] quiet_q;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         quiet_q <= '0;
      else if (!ctl2_q[CTL2_WDOG_ON] || access)
         quiet_q <= '0;
      else if (wd_timeout)
         quiet_q <= WDOG_CNT_W'(1);
      else
         quiet_q <= quiet_q + 1'b1;
   end

   // ------------------------------------------------------------
   // event flags
   // ------------------------------------------------------------
   dic_event_detect #(
      .POL_SUPPORT (POL_SUPPORT)
   ) u_events (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .line_ev   (line_ev),
      .ring_both (ctl2_q[CTL2_RING_BOTH]),
      .set_pulse (set_pulse)
   );

   // writing 0 clears, writing 1 keeps; a new event beats the clear.
   // the end-of-burst ring event is lost if the host has not
   // cleared the start flag in time, since it is already set
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         flags_q <= SRC_RST;
      else if (wr_pend_q && wr_idx_q == REG_SRC_IDX)
         flags_q <= (flags_q & wbyte) | set_pulse;
      else
         flags_q <= flags_q | set_pulse;
   end

   // ------------------------------------------------------------
   // shared pin and path outputs
   // ------------------------------------------------------------
   assign any_irq = |(flags_q & mask_q);

   // pin stays registered in both modes to avoid glitches on a switch
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         monitor_or_irq_pin <= 1'b0;
      else if (ctl2_q[CTL2_PIN_SEL])
         monitor_or_irq_pin <= ctl2_q[CTL2_POLARITY] ? any_irq : !any_irq;
      else
         monitor_or_irq_pin <= monitor_stream;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         offhook_ctl    <= HOOK_RST;
         hybrid_connect <= 1'b0;
         rx_path_on     <= 1'b0;
      end
      else
      begin
         offhook_ctl    <= offhook_q;
         hybrid_connect <= ctl2_q[CTL2_HYBRID];
         rx_path_on     <= ctl2_q[CTL2_RX_ON];
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   irq_polarity_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ctl2_q[CTL2_PIN_SEL] |=> monitor_or_irq_pin
         == ($past(ctl2_q[CTL2_POLARITY]) ? $past(any_irq) : !$past(any_irq)))
      else $error("interrupt pin polarity wrong");

   monitor_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !ctl2_q[CTL2_PIN_SEL] |=> monitor_or_irq_pin == $past(monitor_stream))
      else $error("monitor stream not on pin");

   mask_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (ctl2_q[CTL2_PIN_SEL] && (flags_q & mask_q) == 8'h00)
         |=> monitor_or_irq_pin == !$past(ctl2_q[CTL2_POLARITY]))
      else $error("masked flag drove the pin");

   wdog_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ctl2_q[CTL2_WDOG_ON] |=> ctl2_q[CTL2_WDOG_ON])
      else $error("watchdog enable was cleared");

   wdog_onhook_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wd_timeout |=> !offhook_q ##1 !offhook_ctl)
      else $error("timeout did not force on-hook");

   ring_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(line_ev.ring_active) |=> flags_q[EV_RING])
      else $error("ring start not flagged");

   ring_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($fell(line_ev.ring_active) && ctl2_q[CTL2_RING_BOTH]) |=> flags_q[EV_RING])
      else $error("ring end not flagged");

   flag_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !(wr_pend_q && wr_idx_q == REG_SRC_IDX) |=> (flags_q & $past(flags_q)) == $past(flags_q))
      else $error("flag dropped without a clear");

   path_bits_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> hybrid_connect == $past(ctl2_q[CTL2_HYBRID])
               && rx_path_on == $past(ctl2_q[CTL2_RX_ON]))
      else $error("path controls not following register");

   wdog_window_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wd_timeout == (quiet_q == QUIET_LEN))
      else $error("watchdog window length wrong");

   hook_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_pend_q && wr_idx_q == REG_HOOK_IDX) |=> offhook_q == $past(wbyte[HOOK_OFFHOOK]))
      else $error("hook write not taken");

   flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (set_pulse != 8'h00) |=> (flags_q & $past(set_pulse)) == $past(set_pulse))
      else $error("event lost against a clear");

   pol_flip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (POL_SUPPORT && $past(rst_n) && $changed(line_ev.line_voltage_msb))
         |=> flags_q[EV_POL_FLIP])
      else $error("polarity reversal not flagged");

   loop_max_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(&line_ev.loop_current_field) |=> flags_q[EV_LOOP_MAX])
      else $error("loop current maximum not flagged");

   tip_ground_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(line_ev.tip_ground_status) |=> flags_q[EV_TIP_GND])
      else $error("tip ground not flagged");
endmodule // dic_irq_ctl

/* File: verif/dic_host_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// host processor on the register bus
// ------------------------------------------------------------
module dic_host_model
   import dic_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        hreadyout,
   input  wire logic        hresp,
   input  wire logic [31:0] hrdata,
   output dic_ahb_req_t     ahb_req
);
   dic_ahb_req_t q;
   int           bad_resp = 0;

   // one slave, so its ready is the bus ready
   always_comb
   begin
      ahb_req        = q;
      ahb_req.hready = hreadyout;
   end

   initial q = '{hsel: 1'b0, haddr: 8'h00, htrans: 2'h0, hwrite: 1'b0,
                 hsize: 3'h2, hwdata: 32'h0, hready: 1'b1};

   // single word transfer, entered just after a rising edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                       output logic [7:0] r);
      q.hsel   <= 1'b1;
      q.haddr  <= a;
      q.htrans <= HTRANS_NONSEQ;
      q.hwrite <= w;
      q.hwdata <= ~q.hwdata; // stale data never looks valid
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      q.hsel   <= 1'b0;
      q.htrans <= 2'h0;
      q.hwdata <= {24'h0, d};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      r = hrdata[7:0];
      if (hresp !== HRESP_OKAY)
         bad_resp++;
   endtask
endmodule // dic_host_model

/* File: verif/daa_interrupt_watchdog_control_tb.sv */
`timescale 1ns/1ps
module daa_interrupt_watchdog_control_tb;
   import dic_pkg::*;
   localparam logic [7:0] CA = {2'h0, REG_CTL2_IDX, 2'h0};
   localparam logic [7:0] MA = {2'h0, REG_MASK_IDX, 2'h0};
   localparam logic [7:0] SA = {2'h0, REG_SRC_IDX, 2'h0};
   localparam logic [7:0] HA = {2'h0, REG_HOOK_IDX, 2'h0};

   logic         ref_clk = 1'b0;
   logic         rst_n   = 1'b0;
   logic         mon     = 1'b0;
   dic_line_ev_t ev      = '0;
   dic_ahb_req_t ahb_req;
   logic         hreadyout, hresp, pin, offhook, hybrid, rx_on;
   logic [31:0]  hrdata;
   logic [16:0]  seed    = 17'h14E6B;
   logic [7:0]   ctl_m   = 8'h00;
   logic [7:0]   msk_m   = 8'h00;
   logic [7:0]   src_m   = 8'h00;
   logic [1:0]   hist;
   int           fails   = 0;
   int           total_checks = 0;
   int           cyc     = 0;

   // ------------------------------------------------------------
   // clock, host and design
   // ------------------------------------------------------------
   always #12.5 ref_clk = ~ref_clk;

   dic_host_model hst (.ref_clk(ref_clk), .hreadyout(hreadyout), .hresp(hresp),
                       .hrdata(hrdata), .ahb_req(ahb_req));

   // short watchdog window keeps the run brief
   dic_irq_ctl #(.WDOG_LEN(50)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .ahb_req(ahb_req), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .line_ev(ev), .monitor_stream(mon),
      .monitor_or_irq_pin(pin), .offhook_ctl(offhook), .hybrid_connect(hybrid),
      .rx_path_on(rx_on));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction

   task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
      total_checks++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
      end
   endtask

   task automatic cyc_n(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      hst.xfer(a, 1'b1, d, r);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
      logic [7:0] r;
      hst.xfer(a, 1'b0, 8'h00, r);
      chk(r, e, m);
   endtask

   // pin settles two edges after a register change
   task automatic pinchk();
      logic e;
      cyc_n(2);
      e = (|(src_m & msk_m)) ? ctl_m[6] : ~ctl_m[6];
      chk({7'h0, pin}, {7'h0, e}, "interrupt pin");
   endtask

   // drive one line event source; polarity source toggles
   task automatic ev_set(input int i, input logic v);
      case (i)
         7: ev.ring_active <= v;
         6: ev.rx_overload <= v;
         5: ev.frame_lost <= v;
         4: ev.billing_tone <= v;
         3: ev.dropout <= v;
         2: ev.loop_current_field <= {LCS_W{v}};
         1: ev.tip_ground_status <= v;
         default: if (v) ev.line_voltage_msb <= ~ev.line_voltage_msb;
      endcase
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // hang guard
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails++;
         end_of_test();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      cyc_n(5);
      rst_n <= 1'b1;
      cyc_n(1);
      rdc(CA, 8'h00, "control reset");
      rdc(MA, 8'h00, "mask reset");
      rdc(SA, 8'h00, "flags reset");
      rdc(HA, 8'h00, "hook reset");
      // random control values, watchdog bit kept clear for now
      repeat (6)
      begin
         seed = lfsr(seed);
         wr(CA, seed[7:0] & 8'hEF);
         ctl_m = seed[7:0] & 8'hEF & CTL2_RW_BITS;
         rdc(CA, ctl_m, "control readback");
         chk({6'h0, hybrid, rx_on}, {6'h0, ctl_m[1:0]}, "path enables");
      end
      // unmapped place is ignored
      wr(8'h20, 8'hFF);
      rdc(8'h20, 8'h00, "unmapped read");
      // monitor mode: pin follows stream one cycle late
      wr(CA, 8'h00);
      ctl_m = 8'h00;
      for (int k = 0; k < 12; k++)
      begin
         cyc_n(1);
         if (k >= 2)
            chk({7'h0, pin}, {7'h0, hist[1]}, "monitor output");
         seed = lfsr(seed);
         hist = {hist[0], seed[0]};
         mon <= seed[0];
      end
      // every source: masked off, then on, then cleared
      for (int i = 0; i < 8; i++)
      begin
         ctl_m = 8'h80 | (i[0] ? 8'h40 : 8'h00);
         wr(CA, ctl_m);
         seed = lfsr(seed);
         msk_m = seed[7:0] & ~(8'h01 << i);
         wr(MA, msk_m);
         rdc(MA, msk_m, "mask readback");
         ev_set(i, 1'b1);
         cyc_n(4);
         src_m = 8'h01 << i;
         rdc(SA, src_m, "source flag");
         pinchk();
         msk_m = 8'h01 << i;
         wr(MA, msk_m);
         pinchk();
         ev_set(i, 1'b0);
         cyc_n(3);
         pinchk();
         wr(SA, ~src_m);
         src_m = 8'h00;
         pinchk();
         ctl_m = 8'h00;
         wr(CA, ctl_m);
         rdc(SA, 8'h00, "flag after clear");
      end
      // ring interrupt per burst, one or both edges
      for (int b = 0; b < 2; b++)
      begin
         wr(CA, b[0] ? 8'h84 : 8'h80);
         ev_set(7, 1'b1);
         cyc_n(4);
         rdc(SA, 8'h80, "ring start flag");
         wr(SA, 8'h00);
         ev_set(7, 1'b0);
         cyc_n(4);
         rdc(SA, b[0] ? 8'h80 : 8'h00, "ring end flag");
         wr(SA, 8'h00);
      end
      // watchdog: sticky enable, restart by access, timeout drops hook
      wr(HA, 8'h01);
      cyc_n(3);
      chk({7'h0, offhook}, 8'h01, "off hook");
      wr(CA, 8'h10);
      wr(CA, 8'h00);
      rdc(CA, 8'h10, "watchdog enable sticky");
      repeat (3)
      begin
         cyc_n(35);
         rdc(HA, 8'h01, "hook kept");
      end
      cyc_n(40);
      chk({7'h0, offhook}, 8'h01, "hook before timeout");
      cyc_n(20);
      chk({7'h0, offhook}, 8'h00, "hook after timeout");
      rdc(HA, 8'h00, "hook bit cleared");
      wr(HA, 8'h01);
      cyc_n(3);
      chk({7'h0, offhook}, 8'h01, "off hook again");
      // hardware reset mid-run is the only way back for the enable;
      // line voltage bit stays high, which must not read as a reversal
      rst_n <= 1'b0;
      cyc_n(2);
      rst_n <= 1'b1;
      cyc_n(1);
      rdc(CA, 8'h00, "control after reset");
      rdc(SA, 8'h00, "no flag from reset");
      chk({7'h0, offhook}, 8'h00, "on hook after reset");
      chk(hst.bad_resp[7:0], 8'h00, "bus response");
      end_of_test();
   end
endmodule // daa_interrupt_watchdog_control_tb
